//--- rtl/edr_pkg.sv
// Shared constants and types for the controller and DMA register bank with access hazards.
package edr_pkg;

    // Target of one host instruction.
    localparam logic [1:0] TGT_DMA = 2'h0;
    localparam logic [1:0] TGT_CTRL = 2'h1;
    localparam logic [1:0] TGT_EXT = 2'h2;
    localparam logic [1:0] TGT_OTHER = 2'h3;

    // Register indices within the bank.
    localparam logic [3:0] IDX_TX_REQ = 4'h0;
    localparam logic [3:0] IDX_RX_REQ = 4'h1;
    localparam logic [3:0] IDX_STATUS = 4'h2;
    localparam logic [3:0] IDX_PERMIT = 4'h3;
    localparam logic [3:0] IDX_MISSED = 4'h4;
    localparam logic [3:0] IDX_BIT_RATE = 4'h5;
    localparam logic [3:0] IDX_STATION_HI = 4'h6;
    localparam logic [3:0] IDX_CTRL_MODE = 4'h7;
    localparam logic [3:0] IDX_CTRL_IPERMIT = 4'h8;

    // Field positions.
    localparam int REQ_BIT = 0;
    localparam int HALF_W = 16;

    // Values after reset and half-word masks.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_BIT_RATE = 32'h0000_0000;
    localparam logic [31:0] UPPER_MASK = 32'hffff_0000;
    localparam logic [31:0] LOWER_MASK = 32'h0000_ffff;

    // Hazard history of the previous host instruction.
    typedef enum logic [3:0] {
        EDR_H_CLEAN = 4'b0001,
        EDR_H_CWR = 4'b0010,
        EDR_H_CRD = 4'b0100,
        EDR_H_DRD = 4'b1000
    } edr_hist_t;

    typedef struct packed {
        logic write;
        logic indirect;
        logic [1:0] target;
        logic [3:0] idx;
        logic [31:0] wdata;
    } edr_req_t;

    typedef struct packed {
        logic upper_zero;
        logic upper_copy;
        logic br_garbage;
        logic ext_corrupt;
    } edr_haz_t;

endpackage : edr_pkg

//--- rtl/edr_hazard.sv
// Tracks the previous host access and flags the back-to-back access hazards.
`timescale 1ns/1ps
module edr_hazard (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input edr_pkg::edr_req_t req_i,
    output edr_pkg::edr_haz_t haz_o
);

    edr_pkg::edr_hist_t hist_q;
    edr_pkg::edr_hist_t hist_d;
    logic plain_ind;
    logic is_ctrl;
    logic is_dma;
    logic affected_wr;
    logic affected_rd;

    always_comb begin
        plain_ind = req_valid_i && req_i.indirect;
        is_ctrl = (req_i.target == edr_pkg::TGT_CTRL);
        is_dma = (req_i.target == edr_pkg::TGT_DMA);
        // The interrupt permit register has a reserved upper half, so writes cannot hurt it.
        affected_wr = is_ctrl && (req_i.idx == edr_pkg::IDX_STATION_HI);
        affected_rd = is_ctrl && ((req_i.idx == edr_pkg::IDX_STATION_HI) ||
                      (req_i.idx == edr_pkg::IDX_CTRL_MODE));
        haz_o.upper_zero = plain_ind && !req_i.write && affected_wr &&
                           (hist_q == edr_pkg::EDR_H_CWR);
        haz_o.upper_copy = plain_ind && !req_i.write && affected_rd &&
                           (hist_q == edr_pkg::EDR_H_CRD);
        haz_o.br_garbage = plain_ind && req_i.write && is_dma &&
                           (req_i.idx == edr_pkg::IDX_BIT_RATE) &&
                           (hist_q != edr_pkg::EDR_H_CLEAN) &&
                           (hist_q != edr_pkg::EDR_H_CWR);
        haz_o.ext_corrupt = plain_ind && (req_i.target == edr_pkg::TGT_EXT) &&
                            (hist_q != edr_pkg::EDR_H_CLEAN) &&
                            (hist_q != edr_pkg::EDR_H_CWR);
        hist_d = hist_q;
        if (req_valid_i) begin
            if (is_ctrl && req_i.write) begin
                hist_d = edr_pkg::EDR_H_CWR;
            end else if (is_ctrl) begin
                hist_d = edr_pkg::EDR_H_CRD;
            end else if (is_dma && !req_i.write && (req_i.idx != edr_pkg::IDX_BIT_RATE)) begin
                hist_d = edr_pkg::EDR_H_DRD;
            end else begin
                hist_d = edr_pkg::EDR_H_CLEAN;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hist_q <= edr_pkg::EDR_H_CLEAN;
        end else begin
            hist_q <= hist_d;
        end
    end

endmodule : edr_hazard

//--- rtl/edr_regbank.sv
// Controller and DMA register bank that reproduces the documented access hazards.
`timescale 1ns/1ps
module edr_regbank (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input edr_pkg::edr_req_t req_i,
    input wire logic tx_done_i,
    input wire logic rx_done_i,
    input wire logic [31:0] status_evt_i,
    input wire logic missed_evt_i,
    output logic rvalid_o,
    output logic [31:0] rdata_o,
    output logic ext_strobe_o,
    output logic ext_corrupt_o,
    output logic transmit_request_bit_o,
    output logic receive_request_bit_o,
    output logic [31:0] combined_status_o,
    output logic [31:0] status_permit_o,
    output logic [31:0] bit_rate_o,
    output logic [31:0] missed_count_o
);

    edr_pkg::edr_haz_t haz;

    logic tx_req_q;
    logic tx_req_d;
    logic rx_req_q;
    logic rx_req_d;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] permit_q;
    logic [31:0] permit_d;
    logic [31:0] missed_q;
    logic [31:0] missed_d;
    logic [31:0] bit_rate_q;
    logic [31:0] bit_rate_d;
    logic [31:0] station_hi_q;
    logic [31:0] station_hi_d;
    logic [31:0] mode_q;
    logic [31:0] mode_d;
    logic [31:0] ipermit_q;
    logic [31:0] ipermit_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] prev_rd_q;
    logic [31:0] prev_rd_d;
    logic rvalid_q;
    logic rvalid_d;
    logic ext_strobe_q;
    logic ext_strobe_d;
    logic ext_corrupt_q;
    logic ext_corrupt_d;

    logic wr_dma;
    logic wr_ctrl;
    logic rd_bank;
    logic [31:0] raw;

    edr_hazard u_hazard (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .req_valid_i(req_valid_i),
        .req_i(req_i),
        .haz_o(haz)
    );

    // Register state.
    always_comb begin
        wr_dma = req_valid_i && req_i.write && (req_i.target == edr_pkg::TGT_DMA);
        wr_ctrl = req_valid_i && req_i.write && (req_i.target == edr_pkg::TGT_CTRL);
        tx_req_d = tx_req_q;
        rx_req_d = rx_req_q;
        permit_d = permit_q;
        bit_rate_d = bit_rate_q;
        station_hi_d = station_hi_q;
        mode_d = mode_q;
        ipermit_d = ipermit_q;
        // Request bits drop when the frame datapath finishes; a host set in the same cycle wins.
        if (tx_done_i) begin
            tx_req_d = 1'b0;
        end
        if (rx_done_i) begin
            rx_req_d = 1'b0;
        end
        status_d = status_q;
        if (wr_dma && (req_i.idx == edr_pkg::IDX_STATUS)) begin
            status_d = status_q & ~req_i.wdata;
        end
        // Hardware events are ORed after the write-one-to-clear so they are never lost.
        status_d = status_d | status_evt_i;
        missed_d = missed_q;
        if (missed_evt_i) begin
            missed_d = missed_q + 32'h0000_0001;
        end
        if (wr_dma) begin
            unique case (req_i.idx)
                edr_pkg::IDX_TX_REQ: begin
                    if (req_i.wdata[edr_pkg::REQ_BIT]) begin
                        tx_req_d = 1'b1;
                    end else if (!tx_done_i) begin
                        tx_req_d = 1'b0;
                    end
                end
                edr_pkg::IDX_RX_REQ: begin
                    if (req_i.wdata[edr_pkg::REQ_BIT]) begin
                        rx_req_d = 1'b1;
                    end else if (!rx_done_i) begin
                        rx_req_d = 1'b0;
                    end
                end
                edr_pkg::IDX_PERMIT: begin
                    permit_d = req_i.wdata;
                end
                edr_pkg::IDX_BIT_RATE: begin
                    // A hazardous write stores the stale bus word instead of the data.
                    bit_rate_d = haz.br_garbage ? prev_rd_q : req_i.wdata;
                end
                default: begin
                    // Missed counter and status handled above; writes to the counter are dropped.
                    permit_d = permit_q;
                end
            endcase
        end
        if (wr_ctrl) begin
            unique case (req_i.idx)
                edr_pkg::IDX_STATION_HI: begin
                    station_hi_d = req_i.wdata;
                end
                edr_pkg::IDX_CTRL_MODE: begin
                    mode_d = req_i.wdata;
                end
                edr_pkg::IDX_CTRL_IPERMIT: begin
                    ipermit_d = req_i.wdata & edr_pkg::LOWER_MASK;
                end
                default: begin
                    mode_d = mode_q;
                end
            endcase
        end
    end

    // Read path and bus side effects.
    always_comb begin
        rd_bank = req_valid_i && !req_i.write &&
                  ((req_i.target == edr_pkg::TGT_DMA) || (req_i.target == edr_pkg::TGT_CTRL));
        raw = edr_pkg::RST_WORD;
        if (req_i.target == edr_pkg::TGT_DMA) begin
            unique case (req_i.idx)
                edr_pkg::IDX_TX_REQ: raw = {31'h0000_0000, tx_req_q};
                edr_pkg::IDX_RX_REQ: raw = {31'h0000_0000, rx_req_q};
                edr_pkg::IDX_STATUS: raw = status_q;
                edr_pkg::IDX_PERMIT: raw = permit_q;
                edr_pkg::IDX_MISSED: raw = missed_q;
                edr_pkg::IDX_BIT_RATE: raw = bit_rate_q;
                default: raw = edr_pkg::RST_WORD;
            endcase
        end else if (req_i.target == edr_pkg::TGT_CTRL) begin
            unique case (req_i.idx)
                edr_pkg::IDX_STATION_HI: raw = station_hi_q;
                edr_pkg::IDX_CTRL_MODE: raw = mode_q;
                edr_pkg::IDX_CTRL_IPERMIT: raw = ipermit_q;
                default: raw = edr_pkg::RST_WORD;
            endcase
        end
        rdata_d = rdata_q;
        prev_rd_d = prev_rd_q;
        rvalid_d = rd_bank;
        if (rd_bank) begin
            if (haz.upper_zero) begin
                rdata_d = raw & edr_pkg::LOWER_MASK;
            end else if (haz.upper_copy) begin
                rdata_d = (prev_rd_q & edr_pkg::UPPER_MASK) |
                          (raw & edr_pkg::LOWER_MASK);
            end else begin
                rdata_d = raw;
            end
            // The true register word lingers on the internal bus for the next access.
            prev_rd_d = raw;
        end
        ext_strobe_d = req_valid_i && (req_i.target == edr_pkg::TGT_EXT);
        ext_corrupt_d = haz.ext_corrupt;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_req_q <= 1'b0;
            rx_req_q <= 1'b0;
            status_q <= edr_pkg::RST_WORD;
            permit_q <= edr_pkg::RST_WORD;
            missed_q <= edr_pkg::RST_WORD;
            bit_rate_q <= edr_pkg::RST_BIT_RATE;
            station_hi_q <= edr_pkg::RST_WORD;
            mode_q <= edr_pkg::RST_WORD;
            ipermit_q <= edr_pkg::RST_WORD;
            rdata_q <= edr_pkg::RST_WORD;
            prev_rd_q <= edr_pkg::RST_WORD;
            rvalid_q <= 1'b0;
            ext_strobe_q <= 1'b0;
            ext_corrupt_q <= 1'b0;
        end else begin
            tx_req_q <= tx_req_d;
            rx_req_q <= rx_req_d;
            status_q <= status_d;
            permit_q <= permit_d;
            missed_q <= missed_d;
            bit_rate_q <= bit_rate_d;
            station_hi_q <= station_hi_d;
            mode_q <= mode_d;
            ipermit_q <= ipermit_d;
            rdata_q <= rdata_d;
            prev_rd_q <= prev_rd_d;
            rvalid_q <= rvalid_d;
            ext_strobe_q <= ext_strobe_d;
            ext_corrupt_q <= ext_corrupt_d;
        end
    end

    always_comb begin
        rvalid_o = rvalid_q;
        rdata_o = rdata_q;
        ext_strobe_o = ext_strobe_q;
        ext_corrupt_o = ext_corrupt_q;
        transmit_request_bit_o = tx_req_q;
        receive_request_bit_o = rx_req_q;
        combined_status_o = status_q;
        status_permit_o = permit_q;
        bit_rate_o = bit_rate_q;
        missed_count_o = missed_q;
    end

endmodule : edr_regbank

//--- tb/edr_regbank_checker.sv
// Concurrent checks on the register bank ports.
`timescale 1ns/1ps
module edr_regbank_checker (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input edr_pkg::edr_req_t req_i,
    input wire logic missed_evt_i,
    input wire logic [31:0] rdata_o,
    input wire logic ext_strobe_o,
    input wire logic ext_corrupt_o,
    input wire logic [31:0] bit_rate_o,
    input wire logic [31:0] missed_count_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence ctrl_wr;
        req_valid_i && req_i.write && req_i.target == edr_pkg::TGT_CTRL;
    endsequence
    sequence ctrl_rd;
        req_valid_i && !req_i.write && !req_i.indirect && req_i.target == edr_pkg::TGT_CTRL;
    endsequence
    // Reads of the bit-rate register leave later accesses clean, so they are excluded.
    sequence dma_rd;
        req_valid_i && !req_i.write && req_i.target == edr_pkg::TGT_DMA
            && req_i.idx != edr_pkg::IDX_BIT_RATE;
    endsequence
    sequence ind_rd(logic [3:0] i);
        req_valid_i && !req_i.write && req_i.indirect && req_i.target == edr_pkg::TGT_CTRL
            && req_i.idx == i;
    endsequence
    sequence br_wr(logic ind);
        req_valid_i && req_i.write && req_i.indirect == ind && req_i.target == edr_pkg::TGT_DMA
            && req_i.idx == edr_pkg::IDX_BIT_RATE;
    endsequence
    AST_MISSED_RO: assert property (
        req_valid_i && req_i.write && req_i.target == edr_pkg::TGT_DMA
            && req_i.idx == edr_pkg::IDX_MISSED && !missed_evt_i |=> $stable(missed_count_o))
        else $error("missed counter changed by a host write");
    AST_UPPER_ZERO: assert property (
        ctrl_wr ##1 ind_rd(edr_pkg::IDX_STATION_HI) |=> rdata_o[31:16] == 16'h0000)
        else $error("upper half not zero after write");
    AST_RESERVED_UPPER: assert property (
        req_valid_i && !req_i.write && req_i.target == edr_pkg::TGT_CTRL
            && req_i.idx == edr_pkg::IDX_CTRL_IPERMIT |=> rdata_o[31:16] == 16'h0000)
        else $error("reserved upper half not zero");
    AST_UPPER_COPY: assert property (
        ctrl_rd ##1 ind_rd(edr_pkg::IDX_CTRL_MODE)
            |=> ((rdata_o ^ $past(rdata_o)) & edr_pkg::UPPER_MASK) == 32'h0000_0000)
        else $error("upper half not copied from previous read");
    AST_BR_DIRECT: assert property (
        br_wr(1'b0) |=> bit_rate_o == $past(req_i.wdata))
        else $error("direct bit-rate write not stored");
    AST_BR_STALE: assert property (
        dma_rd ##1 br_wr(1'b1) |=> bit_rate_o == $past(rdata_o))
        else $error("hazarded bit-rate write not stale");
    AST_EXT_BAD: assert property (
        dma_rd ##1 (req_valid_i && req_i.indirect && req_i.target == edr_pkg::TGT_EXT)
            |=> ext_strobe_o && ext_corrupt_o)
        else $error("external access after read not flagged");
    AST_EXT_GOOD: assert property (
        req_valid_i && !req_i.indirect && req_i.target == edr_pkg::TGT_EXT
            |=> ext_strobe_o && !ext_corrupt_o)
        else $error("direct external access flagged");
endmodule : edr_regbank_checker

//--- tb/edr_host_model.sv
// Host core model that issues one register instruction per cycle.
`timescale 1ns/1ps
module edr_host_model (
    input wire logic sys_clk_i,
    input wire logic [31:0] rdata_i,
    output logic req_valid_o,
    output edr_pkg::edr_req_t req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    task automatic issue(input logic w, input logic ind, input logic [1:0] t,
                         input logic [3:0] i, input logic [31:0] d);
        @(posedge sys_clk_i);
        #1;
        req_valid_o = 1'b1;
        req_o = '{w, ind, t, i, d};
    endtask : issue
    // Released request lines flip so that no stale instruction looks valid.
    task automatic idle();
        @(posedge sys_clk_i);
        #1;
        req_valid_o = 1'b0;
        req_o = ~req_o;
    endtask : idle
    task automatic nop();
        issue(1'b0, 1'b0, edr_pkg::TGT_OTHER, 4'h0, 32'h0000_0000);
    endtask : nop
    // A live transfer is never re-armed or cleared; the bit is read before any write.
    task automatic start_req(input logic [3:0] i);
        issue(1'b0, 1'b0, edr_pkg::TGT_DMA, i, 32'h0000_0000);
        idle();
        if (rdata_i[edr_pkg::REQ_BIT] === 1'b0) begin
            issue(1'b1, 1'b0, edr_pkg::TGT_DMA, i, 32'h0000_0001);
            idle();
        end
    endtask : start_req
    // Interrupts are not modelled, so the pair always runs unbroken and is never skipped.
    task automatic write_status(input logic [31:0] v);
        issue(1'b1, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_MISSED, v);
        issue(1'b1, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_STATUS, v);
        idle();
    endtask : write_status
endmodule : edr_host_model

//--- tb/edr_regbank_bench.sv
// Self-checking bench for the register bank and its access hazards.
`timescale 1ns/1ps
module edr_regbank_bench;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic tx_done = 1'b0, rx_done = 1'b0, missed_evt = 1'b0;
    logic [31:0] status_evt = 32'h0000_0000;
    logic req_valid, rvalid, ext_strobe, ext_corrupt, tx_bit, rx_bit;
    logic [31:0] rdata, status, permit, bit_rate, missed;
    edr_pkg::edr_req_t req;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    edr_regbank i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid),
        .req_i(req), .tx_done_i(tx_done), .rx_done_i(rx_done), .status_evt_i(status_evt),
        .missed_evt_i(missed_evt), .rvalid_o(rvalid), .rdata_o(rdata),
        .ext_strobe_o(ext_strobe), .ext_corrupt_o(ext_corrupt),
        .transmit_request_bit_o(tx_bit), .receive_request_bit_o(rx_bit),
        .combined_status_o(status), .status_permit_o(permit), .bit_rate_o(bit_rate),
        .missed_count_o(missed));
    edr_host_model i_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .req_valid_o(req_valid),
        .req_o(req));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic t_request();
        check(missed, 32'h0000_0000);
        i_host.start_req(edr_pkg::IDX_TX_REQ);
        i_host.start_req(edr_pkg::IDX_RX_REQ);
        check({30'h0, tx_bit, rx_bit}, 32'h0000_0003);
        i_host.start_req(edr_pkg::IDX_TX_REQ);
        check(rdata, 32'h0000_0001);
        check({31'h0, rvalid}, 32'h0000_0001);
    endtask : t_request
    task automatic t_status();
        @(posedge sys_clk_i);
        #1;
        status_evt = 32'h0003_0005;
        missed_evt = 1'b1;
        @(posedge sys_clk_i);
        #1;
        status_evt = 32'h0000_0000;
        missed_evt = 1'b0;
        i_host.write_status(32'h0000_0005);
        check(missed, 32'h0000_0001);
        check(status, 32'h0003_0000);
        check({31'h0, rvalid}, 32'h0000_0000);
    endtask : t_status
    task automatic t_release();
        @(posedge sys_clk_i);
        #1;
        tx_done = 1'b1;
        rx_done = 1'b1;
        @(posedge sys_clk_i);
        #1;
        tx_done = 1'b0;
        rx_done = 1'b0;
        check({30'h0, tx_bit, rx_bit}, 32'h0000_0000);
    endtask : t_release
    task automatic t_ctrl();
        i_host.issue(1'b1, 1'b0, edr_pkg::TGT_CTRL, edr_pkg::IDX_CTRL_MODE, 32'h1234_5678);
        i_host.issue(1'b1, 1'b0, edr_pkg::TGT_CTRL, edr_pkg::IDX_STATION_HI, 32'hcafe_0001);
        i_host.issue(1'b0, 1'b1, edr_pkg::TGT_CTRL, edr_pkg::IDX_STATION_HI, 32'h0);
        i_host.idle();
        check(rdata, 32'h0000_0001);
        i_host.issue(1'b1, 1'b0, edr_pkg::TGT_CTRL, edr_pkg::IDX_CTRL_IPERMIT, 32'hffff_00a5);
        i_host.issue(1'b0, 1'b0, edr_pkg::TGT_CTRL, edr_pkg::IDX_STATION_HI, 32'h0);
        i_host.idle();
        check(rdata, 32'hcafe_0001);
        i_host.nop();
        i_host.issue(1'b0, 1'b0, edr_pkg::TGT_CTRL, edr_pkg::IDX_STATION_HI, 32'h0);
        i_host.issue(1'b0, 1'b1, edr_pkg::TGT_CTRL, edr_pkg::IDX_CTRL_MODE, 32'h0);
        i_host.idle();
        check(rdata, 32'hcafe_5678);
        i_host.issue(1'b0, 1'b1, edr_pkg::TGT_CTRL, edr_pkg::IDX_CTRL_IPERMIT, 32'h0);
        i_host.idle();
        check(rdata, 32'h0000_00a5);
    endtask : t_ctrl
    task automatic t_bitrate();
        i_host.issue(1'b1, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_PERMIT, 32'h0000_ffff);
        i_host.issue(1'b0, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_PERMIT, 32'h0);
        i_host.issue(1'b1, 1'b1, edr_pkg::TGT_DMA, edr_pkg::IDX_BIT_RATE, 32'h0000_0064);
        i_host.issue(1'b0, 1'b1, edr_pkg::TGT_DMA, edr_pkg::IDX_BIT_RATE, 32'h0);
        i_host.idle();
        check(bit_rate, 32'h0000_ffff);
        check(rdata, 32'h0000_ffff);
        check(permit, 32'h0000_ffff);
        // A fresh DMA read makes the following indirect write hazardous unless the nop separates them.
        i_host.issue(1'b0, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_PERMIT, 32'h0);
        i_host.nop();
        i_host.issue(1'b1, 1'b1, edr_pkg::TGT_DMA, edr_pkg::IDX_BIT_RATE, 32'h0000_0064);
        i_host.idle();
        check(bit_rate, 32'h0000_0064);
        i_host.issue(1'b0, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_PERMIT, 32'h0);
        i_host.issue(1'b1, 1'b0, edr_pkg::TGT_DMA, edr_pkg::IDX_BIT_RATE, 32'h0000_00c8);
        i_host.idle();
        check(bit_rate, 32'h0000_00c8);
    endtask : t_bitrate
    // Each row: hazard expected, preceding register index, addressing mode, separating nop.
    task automatic t_ext();
        logic [6:0] rows [5] = '{7'h4a, 7'h52, 7'h08, 7'h0b, 7'h16};
        for (int k = 0; k < 5; k++) begin
            i_host.issue(1'b0, 1'b0, edr_pkg::TGT_DMA, rows[k][5:2], 32'h0);
            if (rows[k][0]) begin
                i_host.nop();
            end
            i_host.issue(k[0], rows[k][1], edr_pkg::TGT_EXT, 4'h0, 32'h0);
            i_host.idle();
            check({30'h0, ext_strobe, ext_corrupt}, {30'h1, rows[k][6]});
        end
    endtask : t_ext
    initial begin
        repeat (8) @(posedge sys_clk_i);
        #1;
        resetn_i = 1'b1;
        t_request();
        t_status();
        t_release();
        t_ctrl();
        t_bitrate();
        t_ext();
        wrap_up();
    end
endmodule : edr_regbank_bench
bind edr_regbank edr_regbank_checker i_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .missed_evt_i(missed_evt_i), .rdata_o(rdata_o),
    .ext_strobe_o(ext_strobe_o), .ext_corrupt_o(ext_corrupt_o), .bit_rate_o(bit_rate_o),
    .missed_count_o(missed_count_o));
